// >>> verilog/pmsc_defs.svh
// Constants for the power-management status and control block.
// Assumes an 8-bit register port with three registers at chosen indices.
// Behaviour
// [R1] Detect flag, bit 7 of first register, sets on detect event while enabled.
// [R2] Writing 1 to detect-ack bit 6 clears detect flag; reads return 0.
// [R3] Interrupt request while detect flag and interrupt enable bit 5 are set.
// [R4] Reset request when detect flag set, reset enable bit 4 and master enable.
// [R5] Stop-enable bit 3 keeps detection running in stop mode.
// [R6] Master enable bit 2 turns detect logic on and qualifies other bits.
// [R7] Software writes 0 to reserved bit 1 of the first register.
// [R8] Bit 0 of first register enables the bandgap buffer.
// [R9] Write-once bits accept only the first write after their reset.
// [R10] Warning flag bit 7 stays set after the condition until acknowledged.
// [R11] Warning-ack bit 6 clears warning flag only while no warning present.
// [R12] Warning flag sets on warning, including right after any reset.
// [R13] Detect trip select bit 5 is written once after power-on only.
// [R14] Warning trip select bit 4 clears on power-on and survives other resets.
// [R15] Stop2 recovery flag bit 3 sets on recovery from stop2.
// [R16] Writing 1 to stop2 ack bit 2 clears the recovery flag.
// [R17] Write-once bit 0 selects stop3 when 0, stop2 when 1.
// [R18] Write-once option bit picks watchdog clock: 1-kHz source or bus clock.
// [R19] Option bit 3 routes timer external clocks: shared or dedicated.
// [R20] Software checks recovery flag and acknowledges before resuming I/O.
`ifndef PMSC_DEFS_SVH
`define PMSC_DEFS_SVH
`define PMSC_ADDR_W        2
`define PMSC_IDX_DETECT    2'h0
`define PMSC_IDX_WARN      2'h1
`define PMSC_IDX_OPT       2'h2
`define PMSC_B_DFLAG       7
`define PMSC_B_DACK        6
`define PMSC_B_DIE         5
`define PMSC_B_DRE         4
`define PMSC_B_DSE         3
`define PMSC_B_DEN         2
`define PMSC_B_BANDGAP_BUFFER_ENABLE        0
`define PMSC_B_WFLAG       7
`define PMSC_B_WACK        6
`define PMSC_B_DTRIP       5
`define PMSC_B_WTRIP       4
`define PMSC_B_S2FLAG      3
`define PMSC_B_S2ACK       2
`define PMSC_B_S2SEL       0
`define PMSC_B_WDCLK       7
`define PMSC_B_TMRCLK      3
`define PMSC_DETECT_RST    8'h1C
`define PMSC_OPT_RST       8'h00
`endif

// >>> verilog/pmsc_pkg.sv
// Types for the power-management status and control block.
// Assumes pmsc_defs.svh is included by users of the field positions.
package pmsc_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [1:0] addr;
      logic [7:0] wdata;
   } pmsc_bus_t;

   typedef enum logic [1:0] {
      PMSC_RUN   = 2'b00,
      PMSC_STOP  = 2'b01,
      PMSC_WAKE  = 2'b11
   } pmsc_state_t;
endpackage

// >>> verilog/pmsc_ctrl.sv
// Power-management status/control registers: detect, warning, stop2, options.
// Assumes comparator and stop/wake inputs come from other clock domains or
// pins; power-on reset arrives as a separate clocked pulse input POR_EVENT.
`timescale 1ns/1ps
`include "pmsc_defs.svh"
module pmsc_ctrl (
   input  wire logic       CLK,
   input  wire logic       SYS_RST,
   input  wire logic       POR_EVENT,
   input  wire logic       WR,
   input  wire logic       RD,
   input  wire logic [1:0] ADDR,
   input  wire logic [7:0] WDATA,
   output logic      [7:0] RDATA,
   input  wire logic       DETECT_RAW,
   input  wire logic       WARN_RAW,
   input  wire logic       STOP_REQ,
   input  wire logic       WAKE_REQ,
   output logic            IRQ,
   output logic            RST_REQ,
   output logic            DETECT_ON,
   output logic            BANDGAP_ON,
   output logic            DETECT_TRIP,
   output logic            WARN_TRIP,
   output logic            STOP2_MODE,
   output logic            IN_STOP,
   output logic            WDOG_BUSCLK,
   output logic            TMR_DEDICATED
);
   pmsc_pkg::pmsc_bus_t   bus;
   pmsc_pkg::pmsc_state_t state;
   logic [1:0] det_sync, warn_sync, stop_sync, wake_sync;
   logic       det, warn, stop_in, wake_in;
   logic       dflag, die, dre, dse, den, bandgap_buffer_enable;
   logic       wflag, dtrip, wtrip, dtrip_done, s2flag, s2sel, s2_done;
   logic       wdclk, wd_done, tmrclk;
   logic       det_active;
   logic       wr_det, wr_warn, wr_opt;

   assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

   // Reset images of the detect and option registers
   localparam logic [7:0] DET_RST = `PMSC_DETECT_RST;
   localparam logic [7:0] OPT_RST = `PMSC_OPT_RST;

   // The bus is passed in so the continuous assigns see every change of it
   function automatic logic hit(input pmsc_pkg::pmsc_bus_t b,
                                input logic [1:0]          idx);
      hit = b.wr && (b.addr == idx);
   endfunction

   assign wr_det  = hit(bus, `PMSC_IDX_DETECT);
   assign wr_warn = hit(bus, `PMSC_IDX_WARN);
   assign wr_opt  = hit(bus, `PMSC_IDX_OPT);

   // Two-flop synchronisers; only the second stage is read
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         det_sync  <= 2'h0;
         warn_sync <= 2'h0;
         stop_sync <= 2'h0;
         wake_sync <= 2'h0;
      end else begin
         det_sync  <= {det_sync[0], DETECT_RAW};
         warn_sync <= {warn_sync[0], WARN_RAW};
         stop_sync <= {stop_sync[0], STOP_REQ};
         wake_sync <= {wake_sync[0], WAKE_REQ};
      end
   end
   assign det     = det_sync[1];
   assign warn    = warn_sync[1];
   assign stop_in = stop_sync[1];
   assign wake_in = wake_sync[1];

   // Stop sequencing: run -> stop -> wake (one cycle) -> run
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state <= pmsc_pkg::PMSC_RUN;
      end else begin
         case (state)
            pmsc_pkg::PMSC_RUN:  if (stop_in) state <= pmsc_pkg::PMSC_STOP;
            pmsc_pkg::PMSC_STOP: if (wake_in) state <= pmsc_pkg::PMSC_WAKE;
            pmsc_pkg::PMSC_WAKE: state <= pmsc_pkg::PMSC_RUN;
            default:             state <= pmsc_pkg::PMSC_RUN;
         endcase
      end
   end
   assign IN_STOP = (state == pmsc_pkg::PMSC_STOP);

   // Detection is off in stop unless stop-enable is set
   assign det_active = den && (!IN_STOP || dse); // R5 R6

   // Detect control register, reset by SYS_RST only, not by POR_EVENT
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         die  <= DET_RST[`PMSC_B_DIE];
         dre  <= DET_RST[`PMSC_B_DRE];
         dse  <= DET_RST[`PMSC_B_DSE];
         den  <= DET_RST[`PMSC_B_DEN];
         bandgap_buffer_enable <= DET_RST[`PMSC_B_BANDGAP_BUFFER_ENABLE];
      end else if (wr_det) begin
         die  <= bus.wdata[`PMSC_B_DIE]; // R3
         dre  <= bus.wdata[`PMSC_B_DRE]; // R4
         dse  <= bus.wdata[`PMSC_B_DSE]; // R5
         den  <= bus.wdata[`PMSC_B_DEN]; // R6
         bandgap_buffer_enable <= bus.wdata[`PMSC_B_BANDGAP_BUFFER_ENABLE]; // R8
      end
   end

   // Set wins over the acknowledge in the same cycle
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         dflag <= 1'b0;
      end else if (det_active && det) begin
         dflag <= 1'b1; // R1
      end else if (!den) begin
         dflag <= 1'b0; // R6
      end else if (wr_det && bus.wdata[`PMSC_B_DACK]) begin
         dflag <= 1'b0; // R2
      end
   end

   assign IRQ        = dflag && die; // R3
   assign RST_REQ    = dflag && dre && den; // R4
   assign DETECT_ON  = det_active;
   assign BANDGAP_ON = bandgap_buffer_enable; // R8

   // Warning flag: a present warning holds it set, including just after reset
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wflag <= 1'b0;
      end else if (warn) begin
         wflag <= 1'b1; // R10 R12
      end else if (wr_warn && bus.wdata[`PMSC_B_WACK]) begin
         wflag <= 1'b0; // R11
      end
   end

   // Trip selects survive ordinary resets; only power-on clears them
   always_ff @(posedge CLK) begin
      if (POR_EVENT) begin
         dtrip      <= 1'b0;
         dtrip_done <= 1'b0;
         wtrip      <= 1'b0; // R14
      end else if (wr_warn) begin
         wtrip <= bus.wdata[`PMSC_B_WTRIP]; // R14
         if (!dtrip_done) begin
            dtrip      <= bus.wdata[`PMSC_B_DTRIP]; // R13
            dtrip_done <= 1'b1; // R9
         end
      end
   end
   assign DETECT_TRIP = dtrip;
   assign WARN_TRIP   = wtrip;

   // Stop2 select is write-once per reset
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s2sel   <= 1'b0;
         s2_done <= 1'b0;
      end else if (wr_warn && !s2_done) begin
         s2sel   <= bus.wdata[`PMSC_B_S2SEL]; // R17
         s2_done <= 1'b1; // R9
      end
   end
   assign STOP2_MODE = s2sel;

   // Recovery flag set on wake from a stop2 entry; set beats acknowledge
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s2flag <= 1'b0;
      end else if (state == pmsc_pkg::PMSC_WAKE && s2sel) begin
         s2flag <= 1'b1; // R15
      end else if (wr_warn && bus.wdata[`PMSC_B_S2ACK]) begin
         s2flag <= 1'b0; // R16 R20
      end
   end

   // Option register: watchdog clock write-once, timer routing free
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wdclk   <= OPT_RST[`PMSC_B_WDCLK];
         wd_done <= 1'b0;
         tmrclk  <= OPT_RST[`PMSC_B_TMRCLK];
      end else if (wr_opt) begin
         tmrclk <= bus.wdata[`PMSC_B_TMRCLK]; // R19
         if (!wd_done) begin
            wdclk   <= bus.wdata[`PMSC_B_WDCLK]; // R18
            wd_done <= 1'b1; // R9
         end
      end
   end
   assign WDOG_BUSCLK   = wdclk;
   assign TMR_DEDICATED = tmrclk;

   // Read data one cycle after the read strobe; ack bits and bit 1 read 0
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         RDATA <= 8'h00;
      end else if (bus.rd) begin
         RDATA <= 8'h00;
         case (bus.addr)
            `PMSC_IDX_DETECT: begin
               RDATA[`PMSC_B_DFLAG] <= dflag;
               RDATA[`PMSC_B_DIE]   <= die;
               RDATA[`PMSC_B_DRE]   <= dre;
               RDATA[`PMSC_B_DSE]   <= dse;
               RDATA[`PMSC_B_DEN]   <= den;
               RDATA[`PMSC_B_BANDGAP_BUFFER_ENABLE]  <= bandgap_buffer_enable;
            end
            `PMSC_IDX_WARN: begin
               RDATA[`PMSC_B_WFLAG]  <= wflag;
               RDATA[`PMSC_B_DTRIP]  <= dtrip;
               RDATA[`PMSC_B_WTRIP]  <= wtrip;
               RDATA[`PMSC_B_S2FLAG] <= s2flag;
               RDATA[`PMSC_B_S2SEL]  <= s2sel;
            end
            `PMSC_IDX_OPT: begin
               RDATA[`PMSC_B_WDCLK]  <= wdclk;
               RDATA[`PMSC_B_TMRCLK] <= tmrclk;
            end
            default: RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   property p_irq;
      @(posedge CLK) disable iff (SYS_RST) IRQ |-> (dflag && die);
   endproperty
   a_irq: assert property (p_irq) else $error("irq without flag"); // R3

   property p_dflag_set;
      @(posedge CLK) disable iff (SYS_RST) (det_active && det) |=> dflag;
   endproperty
   a_dflag_set: assert property (p_dflag_set) else $error("detect flag not set"); // R1

   property p_dack;
      @(posedge CLK) disable iff (SYS_RST)
         (wr_det && bus.wdata[`PMSC_B_DACK] && !(det_active && det)) |=> !dflag;
   endproperty
   a_dack: assert property (p_dack) else $error("detect ack failed"); // R2

   property p_rst;
      @(posedge CLK) disable iff (SYS_RST) (dflag && dre && den) |-> RST_REQ;
   endproperty
   a_rst: assert property (p_rst) else $error("reset request missing"); // R4

   property p_wack;
      @(posedge CLK) disable iff (SYS_RST) warn |=> wflag;
   endproperty
   a_wack: assert property (p_wack) else $error("warning flag cleared while present"); // R11

   property p_s2flag;
      @(posedge CLK) disable iff (SYS_RST)
         (state == pmsc_pkg::PMSC_WAKE && s2sel) |=> s2flag;
   endproperty
   a_s2flag: assert property (p_s2flag) else $error("stop2 flag not set"); // R15

   property p_s2once;
      @(posedge CLK) disable iff (SYS_RST) s2_done |=> $stable(s2sel);
   endproperty
   a_s2once: assert property (p_s2once) else $error("stop2 select rewritten"); // R9

   property p_wdonce;
      @(posedge CLK) disable iff (SYS_RST) wd_done |=> $stable(wdclk);
   endproperty
   a_wdonce: assert property (p_wdonce) else $error("watchdog select rewritten"); // R18

   // While the master enable is on, a raised detect flag must survive until software acknowledges it
   property p_dflag_hold;
      @(posedge CLK) disable iff (SYS_RST)
         (dflag && den && !(wr_det && bus.wdata[`PMSC_B_DACK])) |=> dflag;
   endproperty
   a_dflag_hold: assert property (p_dflag_hold) else $error("detect flag lost"); // R1

   property p_dack_read;
      @(posedge CLK) disable iff (SYS_RST)
         (bus.rd && bus.addr == `PMSC_IDX_DETECT) |=> !RDATA[`PMSC_B_DACK];
   endproperty
   a_dack_read: assert property (p_dack_read) else $error("detect ack reads 1"); // R2

   // With the master enable off nothing may hold the flag
   property p_den_off;
      @(posedge CLK) disable iff (SYS_RST)
         !den |=> !dflag;
   endproperty
   a_den_off: assert property (p_den_off) else $error("flag set while disabled"); // R6

   property p_rst_off;
      @(posedge CLK) disable iff (SYS_RST)
         !dre |-> !RST_REQ;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("reset without enable"); // R4

   // Stop without stop-enable must switch detection off
   property p_stop_det;
      @(posedge CLK) disable iff (SYS_RST)
         (IN_STOP && !dse) |-> !DETECT_ON;
   endproperty
   a_stop_det: assert property (p_stop_det) else $error("detect active in stop"); // R5

   property p_bandgap_buffer_enable;
      @(posedge CLK) disable iff (SYS_RST)
         wr_det |=> (BANDGAP_ON == $past(bus.wdata[`PMSC_B_BANDGAP_BUFFER_ENABLE]));
   endproperty
   a_bandgap_buffer_enable: assert property (p_bandgap_buffer_enable) else $error("bandgap enable not written"); // R8

   property p_wflag_hold;
      @(posedge CLK) disable iff (SYS_RST)
         (wflag && !(wr_warn && bus.wdata[`PMSC_B_WACK])) |=> wflag;
   endproperty
   a_wflag_hold: assert property (p_wflag_hold) else $error("warning flag lost"); // R10

   // The acknowledge only clears once the warning has gone
   property p_wack_clr;
      @(posedge CLK) disable iff (SYS_RST)
         (wr_warn && bus.wdata[`PMSC_B_WACK] && !warn) |=> !wflag;
   endproperty
   a_wack_clr: assert property (p_wack_clr) else $error("warning ack ignored"); // R11

   // Detect trip select keeps its first value until the next power-on
   property p_dtrip_once;
      @(posedge CLK) disable iff (SYS_RST)
         (dtrip_done && !POR_EVENT) |=> $stable(dtrip);
   endproperty
   a_dtrip_once: assert property (p_dtrip_once) else $error("detect trip rewritten"); // R13

   property p_wtrip_wr;
      @(posedge CLK) disable iff (SYS_RST)
         (wr_warn && !POR_EVENT) |=> (wtrip == $past(bus.wdata[`PMSC_B_WTRIP]));
   endproperty
   a_wtrip_wr: assert property (p_wtrip_wr) else $error("warning trip not written"); // R14

   property p_s2flag_clr;
      @(posedge CLK) disable iff (SYS_RST)
         (wr_warn && bus.wdata[`PMSC_B_S2ACK] && !(state == pmsc_pkg::PMSC_WAKE && s2sel))
            |=> !s2flag;
   endproperty
   a_s2flag_clr: assert property (p_s2flag_clr) else $error("stop2 ack ignored"); // R16

   property p_rd_acks;
      @(posedge CLK) disable iff (SYS_RST)
         (bus.rd && bus.addr == `PMSC_IDX_WARN)
            |=> (!RDATA[`PMSC_B_WACK] && !RDATA[`PMSC_B_S2ACK]);
   endproperty
   a_rd_acks: assert property (p_rd_acks) else $error("ack bits read as 1"); // R16

   property p_tmr;
      @(posedge CLK) disable iff (SYS_RST)
         wr_opt |=> (tmrclk == $past(bus.wdata[`PMSC_B_TMRCLK]));
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer routing not written"); // R19

   // Wake is a single cycle between stop and run; the recovery flag keys on it
   sequence s_wake_seen;
      (state == pmsc_pkg::PMSC_STOP) && wake_in;
   endsequence

   sequence s_wake_exit;
      (state == pmsc_pkg::PMSC_WAKE) ##1 (state == pmsc_pkg::PMSC_RUN);
   endsequence

   property p_wake;
      @(posedge CLK) disable iff (SYS_RST)
         s_wake_seen |=> s_wake_exit;
   endproperty
   a_wake: assert property (p_wake) else $error("wake path broken"); // R15
endmodule // pmsc_ctrl

// >>> test/tb_top.sv
// Self-checking bench for the power-management status and control block.
// Assumes the register port returns read data one cycle after the read strobe.
`timescale 1ns/1ps
`include "pmsc_defs.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
   $display("BAD %0t got %h expected %h", $time, a, b); end end
module tb_top;
   logic       clk, sys_rst, por_event, wr, rd, detect_raw, warn_raw, stop_req, wake_req;
   logic [1:0] addr;
   logic [7:0] wdata, rdata;
   logic       irq, rst_req, detect_on, bandgap_on, detect_trip, warn_trip;
   logic       stop2_mode, in_stop, wdog_busclk, tmr_dedicated;
   int         err_count = 0;
   int         samples_checked = 0;

   pmsc_ctrl pmsc_ctrl_inst (.CLK(clk), .SYS_RST(sys_rst), .POR_EVENT(por_event), .WR(wr),
      .RD(rd), .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .DETECT_RAW(detect_raw),
      .WARN_RAW(warn_raw), .STOP_REQ(stop_req), .WAKE_REQ(wake_req), .IRQ(irq),
      .RST_REQ(rst_req), .DETECT_ON(detect_on), .BANDGAP_ON(bandgap_on),
      .DETECT_TRIP(detect_trip), .WARN_TRIP(warn_trip), .STOP2_MODE(stop2_mode),
      .IN_STOP(in_stop), .WDOG_BUSCLK(wdog_busclk), .TMR_DEDICATED(tmr_dedicated));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   // Read data stands only in the cycle after the strobe, so sample just after that edge
   task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1; addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Inputs pass a two-flop synchroniser, so allow a few cycles to settle
   task automatic settle();
      repeat (6) @(posedge clk);
   endtask

   task automatic t_reset_values();
      logic [7:0] d;
      reg_rd(`PMSC_IDX_DETECT, d); `CHK(d, 8'h1C)
      reg_rd(`PMSC_IDX_WARN, d); `CHK(d, 8'h00)
      reg_rd(`PMSC_IDX_OPT, d); `CHK(d, 8'h00)
      reg_wr(2'h3, 8'hFF);
      reg_rd(2'h3, d); `CHK(d, 8'h00)
   endtask

   task automatic t_detect();
      logic [7:0] d;
      detect_raw <= 1'b1; settle();
      reg_rd(`PMSC_IDX_DETECT, d); `CHK(d, 8'h9C)
      `CHK(rst_req, 1'b1)
      detect_raw <= 1'b0; settle();
      reg_wr(`PMSC_IDX_DETECT, 8'h24);
      reg_rd(`PMSC_IDX_DETECT, d); `CHK(d, 8'hA4)
      `CHK(irq, 1'b1)
      `CHK(rst_req, 1'b0)
      `CHK(detect_on, 1'b1)
      reg_wr(`PMSC_IDX_DETECT, 8'h64);
      reg_rd(`PMSC_IDX_DETECT, d); `CHK(d, 8'h24)
      `CHK(irq, 1'b0)
      // Master enable off: an event must not reach the flag
      reg_wr(`PMSC_IDX_DETECT, 8'h21);
      detect_raw <= 1'b1; settle();
      reg_rd(`PMSC_IDX_DETECT, d); `CHK(d, 8'h21)
      `CHK(detect_on, 1'b0)
      `CHK(bandgap_on, 1'b1)
      `CHK(irq, 1'b0)
      detect_raw <= 1'b0;
      reg_wr(`PMSC_IDX_DETECT, 8'h1C);
      `CHK(bandgap_on, 1'b0)
   endtask

   task automatic t_warning();
      logic [7:0] d;
      warn_raw <= 1'b1; settle();
      reg_wr(`PMSC_IDX_WARN, 8'h40);
      reg_rd(`PMSC_IDX_WARN, d); `CHK(d[7], 1'b1)
      warn_raw <= 1'b0; settle();
      reg_rd(`PMSC_IDX_WARN, d); `CHK(d[7], 1'b1)
      reg_wr(`PMSC_IDX_WARN, 8'h40);
      reg_rd(`PMSC_IDX_WARN, d); `CHK(d[7], 1'b0)
   endtask

   task automatic t_write_once();
      logic [7:0] d;
      reg_wr(`PMSC_IDX_WARN, 8'h31);
      reg_wr(`PMSC_IDX_WARN, 8'h00);
      reg_rd(`PMSC_IDX_WARN, d); `CHK(d, 8'h21)
      `CHK({detect_trip, warn_trip, stop2_mode}, 3'b101)
      reg_wr(`PMSC_IDX_OPT, 8'h88);
      reg_wr(`PMSC_IDX_OPT, 8'h00);
      reg_rd(`PMSC_IDX_OPT, d); `CHK(d, 8'h80)
      `CHK({wdog_busclk, tmr_dedicated}, 2'b10)
      reg_wr(`PMSC_IDX_WARN, 8'h10);
      // A reset that is not power-on keeps the trip selects
      @(posedge clk) sys_rst <= 1'b1;
      @(posedge clk) sys_rst <= 1'b0;
      reg_rd(`PMSC_IDX_WARN, d); `CHK(d, 8'h30)
      reg_rd(`PMSC_IDX_OPT, d); `CHK(d, 8'h00)
      reg_wr(`PMSC_IDX_OPT, 8'h08);
      reg_rd(`PMSC_IDX_OPT, d); `CHK(d, 8'h08)
   endtask

   task automatic t_stop2();
      logic [7:0] d;
      reg_wr(`PMSC_IDX_WARN, 8'h01);
      `CHK(stop2_mode, 1'b1)
      stop_req <= 1'b1; settle();
      stop_req <= 1'b0;
      `CHK(in_stop, 1'b1)
      `CHK(detect_on, 1'b1)
      wake_req <= 1'b1; settle();
      wake_req <= 1'b0; settle();
      `CHK(in_stop, 1'b0)
      reg_rd(`PMSC_IDX_WARN, d); `CHK(d[3], 1'b1)
      reg_wr(`PMSC_IDX_WARN, 8'h04);
      reg_rd(`PMSC_IDX_WARN, d); `CHK(d[3:2], 2'b00)
   endtask

   task automatic end_of_test();
      if (err_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      sys_rst = 1'b1; por_event = 1'b0; wr = 1'b0; rd = 1'b0; addr = 2'h0; wdata = 8'h00;
      detect_raw = 1'b0; warn_raw = 1'b0; stop_req = 1'b0; wake_req = 1'b0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      por_event <= 1'b1;
      @(posedge clk) por_event <= 1'b0;
      t_reset_values();
      t_detect();
      // Write-once bits must see their first writes before other scenarios touch them
      t_write_once();
      t_stop2();
      t_warning();
      end_of_test();
   end

   // Whole run is under 150 cycles; this span of 10000 cycles leaves a wide margin
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end
endmodule // tb_top
